//--- verilog/fprc_defines.vh
// Register map, fields, reset values and timing of the page checker.
`ifndef FPRC_DEFINES_VH
`define FPRC_DEFINES_VH

// Register byte offsets.
`define FPRC_OFS_CTRL      6'h00
`define FPRC_OFS_KEY       6'h04
`define FPRC_OFS_SRC       6'h08
`define FPRC_OFS_DST       6'h0C
`define FPRC_OFS_RESULT    6'h10
`define FPRC_OFS_IRQ_STAT  6'h14
`define FPRC_OFS_IRQ_MASK  6'h18
`define FPRC_OFS_ERASE     6'h1C
`define FPRC_OFS_STATUS    6'h20

// Pass/fail result fields.
`define FPRC_BIT_OVERALL_FAIL   0
`define FPRC_BIT_DST_ADDR_ERR   1
`define FPRC_BIT_SRC_ADDR_ERR   2
`define FPRC_BIT_KEY_ERR        4
`define FPRC_BIT_EXEC_ERR       5
`define FPRC_BIT_MODE_ERR       6

// Interrupt status and mask fields.
`define FPRC_IRQ_DONE      0
`define FPRC_IRQ_FAIL      1

// Control and status fields.
`define FPRC_CTRL_START    0
`define FPRC_STAT_BUSY     0
`define FPRC_STAT_WE_PIN   1
`define FPRC_STAT_PROTECT  2

// Reset values and codes.
`define FPRC_RESULT_RESET  8'h00
`define FPRC_UNLOCK_KEY    8'h5A
`define FPRC_PAGE_LOW_A    8'h00
`define FPRC_PAGE_LOW_B    8'h80

// Flash address space, limit exclusive.
`define FPRC_FLASH_BASE    32'h00000000
`define FPRC_FLASH_LIMIT   32'h00008000
`define FPRC_PAGE_SHIFT    7
`define FPRC_PAGE_BITS     8

// Timing.
`define FPRC_CLK_PERIOD_NS 100
`define FPRC_PROG_TIME_NS  1000
`define FPRC_PROG_CYCLES   (`FPRC_PROG_TIME_NS / `FPRC_CLK_PERIOD_NS)

`endif

//--- verilog/fprc_erase_map.v
// One bit per flash page telling whether the page is erased.
`timescale 1ns/100ps
module fprc_erase_map #(
   parameter ADDR_BITS = 8
) (
   input  wire                 clk,
   input  wire                 reset_n,
   input  wire                 wrEn,
   input  wire [ADDR_BITS-1:0] wrAddr,
   input  wire                 wrData,
   input  wire [ADDR_BITS-1:0] rdAddr,
   output reg                  rdData_reg
);
   localparam DEPTH = 1 << ADDR_BITS;
   reg [DEPTH-1:0] erased_reg;
   genvar i;
   generate
      for (i = 0; i < DEPTH; i = i + 1) begin : gEntry
         // Pages start as not erased so a fresh part demands an erase.
         always @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               erased_reg[i] <= 1'b0;
            end else if (wrEn && (wrAddr == i)) begin
               erased_reg[i] <= wrData;
            end
         end
      end
   endgenerate
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdData_reg <= 1'b0;
      end else begin
         rdData_reg <= erased_reg[rdAddr];
      end
   end
endmodule // fprc_erase_map

//--- verilog/fprc_flash_program_result_checker.v
// Parameter checks and pass/fail reporting for one flash page program.
//
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "fprc_defines.vh"
module fprc_flash_program_result_checker #(
   parameter PROG_CYCLES = `FPRC_PROG_CYCLES
) (
   input  wire        clk,
   input  wire        reset_n,
   input  wire [5:0]  avsAddress,
   input  wire        avsRead,
   input  wire        avsWrite,
   input  wire [31:0] avsWriteData,
   input  wire [3:0]  avsByteEnable,
   output reg  [31:0] avsReadData,
   output reg         avsWaitRequest,
   output reg         irq,
   input  wire        writeEnablePin,
   input  wire        errorProtectFlag
);
   localparam [4:0] ST_IDLE  = 5'h01;
   localparam [4:0] ST_CHECK = 5'h02;
   localparam [4:0] ST_EVAL  = 5'h04;
   localparam [4:0] ST_PROG  = 5'h08;
   localparam [4:0] ST_DONE  = 5'h10;
   localparam PB = `FPRC_PAGE_BITS;
   // The count runs down to zero, so it is loaded one short of the length.
   localparam [15:0] PROG_LOAD = PROG_CYCLES - 1;

   reg  [4:0]    state_reg;
   reg  [4:0]    state_next;
   reg  [7:0]    key_reg;
   reg  [31:0]   src_reg;
   reg  [31:0]   dst_reg;
   reg  [7:0]    result_reg;
   reg  [7:0]    result_next;
   reg  [1:0]    irqStat_reg;
   reg  [1:0]    irqMask_reg;
   reg  [15:0]   count_reg;
   reg  [PB-1:0] page_reg;
   reg  [PB-1:0] erasePage_reg;
   reg           eraseReq_reg;
   reg           weMeta_reg;
   reg           wePin_reg;
   reg  [31:0]   rdValue;
   reg           mapWrEn;
   reg  [PB-1:0] mapWrAddr;
   reg           mapWrData;
   wire          mapErased;
   wire          wrTake;
   wire          startReq;
   wire [31:0]   beMask;
   wire [31:0]   dstOfs;
   wire          dstInFlash;
   wire          srcInFlash;
   wire          keyBad;
   wire          modeBad;
   wire          dstBad;
   wire          paramBad;
   wire          finish;
   wire          failNow;

   assign wrTake   = avsWrite && !avsWaitRequest;
   assign beMask   = {{8{avsByteEnable[3]}}, {8{avsByteEnable[2]}},
                      {8{avsByteEnable[1]}}, {8{avsByteEnable[0]}}};
   assign startReq = wrTake && (avsAddress == `FPRC_OFS_CTRL) &&
                     avsByteEnable[0] && avsWriteData[`FPRC_CTRL_START];

   assign dstOfs     = dst_reg - `FPRC_FLASH_BASE;
   assign dstInFlash = (dst_reg >= `FPRC_FLASH_BASE) &&
                       (dst_reg < `FPRC_FLASH_LIMIT);
   assign srcInFlash = (src_reg >= `FPRC_FLASH_BASE) &&
                       (src_reg < `FPRC_FLASH_LIMIT);
   assign keyBad     = (key_reg != `FPRC_UNLOCK_KEY);
   assign modeBad    = !wePin_reg || errorProtectFlag;
   assign dstBad     = !dstInFlash ||
                       ((dst_reg[7:0] != `FPRC_PAGE_LOW_A) &&
                        (dst_reg[7:0] != `FPRC_PAGE_LOW_B));
   assign paramBad   = keyBad || modeBad || dstBad || srcInFlash;
   assign finish     = (state_reg == ST_DONE);
   assign failNow    = result_reg[`FPRC_BIT_OVERALL_FAIL];

   fprc_erase_map #(
      .ADDR_BITS (PB)
   ) uMap (
      .clk        (clk),
      .reset_n    (reset_n),
      .wrEn       (mapWrEn),
      .wrAddr     (mapWrAddr),
      .wrData     (mapWrData),
      .rdAddr     (dstOfs[`FPRC_PAGE_SHIFT +: PB]),
      .rdData_reg (mapErased)
   );

   // Programming a page uses it up; erase requests wait for an idle slot.
   always @* begin
      mapWrEn   = 1'b0;
      mapWrAddr = erasePage_reg;
      mapWrData = 1'b1;
      if (state_reg == ST_PROG && count_reg == 16'h0000) begin
         mapWrEn   = 1'b1;
         mapWrAddr = page_reg;
         mapWrData = 1'b0;
      end else if (eraseReq_reg && state_reg == ST_IDLE) begin
         mapWrEn   = 1'b1;
      end
   end

   always @* begin
      state_next  = state_reg;
      result_next = result_reg;
      case (state_reg)
         ST_IDLE: begin
            if (startReq) begin
               state_next = ST_CHECK;
            end
         end
         ST_CHECK: begin
            result_next = `FPRC_RESULT_RESET;
            result_next[`FPRC_BIT_KEY_ERR]      = keyBad;
            result_next[`FPRC_BIT_SRC_ADDR_ERR] = srcInFlash;
            result_next[`FPRC_BIT_DST_ADDR_ERR] = dstBad;
            result_next[`FPRC_BIT_MODE_ERR]     = modeBad;
            result_next[`FPRC_BIT_OVERALL_FAIL] = paramBad;
            state_next = ST_EVAL;
         end
         ST_EVAL: begin
            if (failNow) begin
               state_next = ST_DONE;
            end else if (!mapErased) begin
               result_next[`FPRC_BIT_EXEC_ERR]     = 1'b1;
               result_next[`FPRC_BIT_OVERALL_FAIL] = 1'b1;
               state_next = ST_DONE;
            end else begin
               state_next = ST_PROG;
            end
         end
         ST_PROG: begin
            if (count_reg == 16'h0000) begin
               state_next = ST_DONE;
            end
         end
         ST_DONE: begin
            state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always @* begin
      rdValue = 32'h00000000;
      case (avsAddress)
         `FPRC_OFS_KEY:      rdValue = {24'h000000, key_reg};
         `FPRC_OFS_SRC:      rdValue = src_reg;
         `FPRC_OFS_DST:      rdValue = dst_reg;
         `FPRC_OFS_RESULT:   rdValue = {24'h000000, result_reg};
         `FPRC_OFS_IRQ_STAT: rdValue = {30'h00000000, irqStat_reg};
         `FPRC_OFS_IRQ_MASK: rdValue = {30'h00000000, irqMask_reg};
         `FPRC_OFS_STATUS:   rdValue = {29'h00000000, errorProtectFlag,
                                        wePin_reg, (state_reg != ST_IDLE)};
         default:            rdValue = 32'h00000000;
      endcase
   end

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg      <= ST_IDLE;
         key_reg        <= 8'h00;
         src_reg        <= 32'h00000000;
         dst_reg        <= 32'h00000000;
         result_reg     <= `FPRC_RESULT_RESET;
         irqStat_reg    <= 2'h0;
         irqMask_reg    <= 2'h0;
         count_reg      <= 16'h0000;
         page_reg       <= {PB{1'b0}};
         erasePage_reg  <= {PB{1'b0}};
         eraseReq_reg   <= 1'b0;
         weMeta_reg     <= 1'b0;
         wePin_reg      <= 1'b0;
         avsReadData    <= 32'h00000000;
         avsWaitRequest <= 1'b1;
         irq            <= 1'b0;
      end else begin
         weMeta_reg     <= writeEnablePin;
         wePin_reg      <= weMeta_reg;
         state_reg      <= state_next;
         result_reg     <= result_next;
         // One wait cycle per access, then the request is taken.
         avsWaitRequest <= !((avsRead || avsWrite) && avsWaitRequest);
         if (avsRead && avsWaitRequest) begin
            avsReadData <= rdValue;
         end
         if (state_reg == ST_CHECK) begin
            page_reg  <= dstOfs[`FPRC_PAGE_SHIFT +: PB];
            count_reg <= PROG_LOAD;
         end else if (state_reg == ST_PROG) begin
            count_reg <= count_reg - 16'h0001;
         end
         if (wrTake && avsAddress == `FPRC_OFS_KEY) begin
            key_reg <= (key_reg & ~beMask[7:0]) |
                       (avsWriteData[7:0] & beMask[7:0]);
         end
         if (wrTake && avsAddress == `FPRC_OFS_SRC) begin
            src_reg <= (src_reg & ~beMask) | (avsWriteData & beMask);
         end
         if (wrTake && avsAddress == `FPRC_OFS_DST) begin
            dst_reg <= (dst_reg & ~beMask) | (avsWriteData & beMask);
         end
         if (wrTake && avsAddress == `FPRC_OFS_IRQ_MASK &&
             avsByteEnable[0]) begin
            irqMask_reg <= avsWriteData[1:0];
         end
         if (wrTake && avsAddress == `FPRC_OFS_ERASE &&
             avsByteEnable[0]) begin
            erasePage_reg <= avsWriteData[PB-1:0];
            eraseReq_reg  <= 1'b1;
         end else if (mapWrEn && mapWrData) begin
            eraseReq_reg  <= 1'b0;
         end
         // A new event outranks a clear in the same cycle.
         irqStat_reg <= (irqStat_reg &
                         ~((wrTake && avsAddress == `FPRC_OFS_IRQ_STAT &&
                            avsByteEnable[0]) ? avsWriteData[1:0] : 2'h0)) |
                        {finish && failNow, finish};
         irq <= |(irqStat_reg & irqMask_reg);
      end
   end
endmodule // fprc_flash_program_result_checker

//--- tb/fprc_result_checker_asserts.sv
// Assertions on bus timing and result reads of the page program checker.
`timescale 1ns/100ps
module fprc_chk (
   input wire        clk,
   input wire        reset_n,
   input wire [5:0]  avsAddress,
   input wire        avsRead,
   input wire        avsWrite,
   input wire [31:0] avsWriteData,
   input wire [3:0]  avsByteEnable,
   input wire [31:0] avsReadData,
   input wire        avsWaitRequest
);
   wire       req = avsRead || avsWrite;
   wire       take = req && !avsWaitRequest;
   reg  [7:0] keyCur_reg;
   reg  [7:0] keyRun_reg;
   // The key is copied at start, since software may rewrite it later.
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         keyCur_reg <= 8'h00;
         keyRun_reg <= 8'h00;
      end else if (take && avsWrite && avsByteEnable[0]) begin
         if (avsAddress == 6'h04)
            keyCur_reg <= avsWriteData[7:0];
         if (avsAddress == 6'h00 && avsWriteData[0])
            keyRun_reg <= keyCur_reg;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   sequence resRead;
      take && avsRead && avsAddress == 6'h10;
   endsequence
   chk_wait_answer: assert property (req && avsWaitRequest |=> take)
      else $error("no answer");
   chk_wait_pulse: assert property (take |=> avsWaitRequest)
      else $error("wait low twice");
   chk_wait_idle: assert property (!req |=> avsWaitRequest)
      else $error("answer unasked");
   chk_empty_read: assert property (take && avsRead &&
      (avsAddress == 6'h00 || avsAddress > 6'h20) |-> avsReadData == 32'h0)
      else $error("empty place nonzero");
   chk_fail_sum: assert property (resRead |->
      avsReadData[0] == |{avsReadData[6:4], avsReadData[2:1]})
      else $error("fail bit wrong");
   chk_spare_zero: assert property (resRead |->
      {avsReadData[31:7], avsReadData[3]} == 26'h0)
      else $error("spare bits set");
   chk_exec_only: assert property (resRead ##0 avsReadData[5] |->
      {avsReadData[6], avsReadData[4:0]} == 6'h01)
      else $error("exec error mixed");
   chk_key_cause: assert property (resRead ##0 avsReadData[4] |->
      keyRun_reg != 8'h5A)
      else $error("key error on good key");
endmodule // fprc_chk

//--- tb/fprc_cpu_model.sv
// Processor model issuing register reads and writes on the bus.
`timescale 1ns/100ps
module fprc_cpu (
   input  wire        clk,
   input  wire        avsWaitRequest,
   input  wire [31:0] avsReadData,
   output reg  [5:0]  avsAddress = 6'h3F,
   output reg         avsRead = 1'b0,
   output reg         avsWrite = 1'b0,
   output reg  [31:0] avsWriteData = 32'h0,
   output reg  [3:0]  avsByteEnable = 4'h0
);
   // Released address and write data lines show inverted values so stale data is never trusted.
   task acc(input w, input [5:0] a, input [31:0] d,
      output [31:0] q, output ok);
      integer n;
      begin
         ok = 1'b0;
         @(posedge clk);
         avsAddress <= a;
         avsWriteData <= d;
         avsByteEnable <= 4'hF;
         avsRead <= !w;
         avsWrite <= w;
         for (n = 0; n < 20 && !ok; n = n + 1) begin
            @(posedge clk);
            ok = avsWaitRequest === 1'b0;
            q = avsReadData;
         end
         avsRead <= 1'b0;
         avsWrite <= 1'b0;
         avsAddress <= ~a;
         avsWriteData <= ~d;
      end
   endtask
endmodule // fprc_cpu

//--- tb/test_flash_program_result_checker.sv
// Self-checking bench for the page program checker.
`timescale 1ns/100ps
`define CHK(g, e) begin checked = checked + 1; if ((g) !== (e)) begin \
   fail_count = fail_count + 1; \
   $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module test_flash_program_result_checker;
   reg         clk = 1'b0;
   reg         reset_n = 1'b0;
   reg         writeEnablePin = 1'b1;
   reg         errorProtectFlag = 1'b0;
   reg  [1:0]  maskVal = 2'h3;
   reg  [31:0] q;
   reg         ok;
   reg  [80:0] rows [0:7];
   integer     i;
   integer     fail_count = 0;
   integer     checked = 0;
   wire [5:0]  avsAddress;
   wire        avsRead;
   wire        avsWrite;
   wire [31:0] avsWriteData;
   wire [3:0]  avsByteEnable;
   wire [31:0] avsReadData;
   wire        avsWaitRequest;
   wire        irq;
   always #50 clk = ~clk;
   fprc_flash_program_result_checker #(
      .PROG_CYCLES (2)
   ) dut (
      .clk              (clk),
      .reset_n          (reset_n),
      .avsAddress       (avsAddress),
      .avsRead          (avsRead),
      .avsWrite         (avsWrite),
      .avsWriteData     (avsWriteData),
      .avsByteEnable    (avsByteEnable),
      .avsReadData      (avsReadData),
      .avsWaitRequest   (avsWaitRequest),
      .irq              (irq),
      .writeEnablePin   (writeEnablePin),
      .errorProtectFlag (errorProtectFlag)
   );
   fprc_cpu cpu (
      .clk            (clk),
      .avsWaitRequest (avsWaitRequest),
      .avsReadData    (avsReadData),
      .avsAddress     (avsAddress),
      .avsRead        (avsRead),
      .avsWrite       (avsWrite),
      .avsWriteData   (avsWriteData),
      .avsByteEnable  (avsByteEnable)
   );
   task complete_run;
      begin
         $display("checked %0d mismatches %0d", checked, fail_count);
         if (fail_count == 0 && checked > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   task bus(input w, input [5:0] a, input [31:0] d);
      begin
         cpu.acc(w, a, d, q, ok);
         if (!ok) begin
            fail_count = fail_count + 1;
            complete_run;
         end
      end
   endtask
   // Row: key, source, destination, erase first, expected result.
   task run(input [80:0] r);
      integer n;
      begin
         if (r[8])
            bus(1'b1, 6'h1C, {24'h0, r[23:16]});
         bus(1'b1, 6'h04, {24'h0, r[80:73]});
         `CHK(irq, 1'b0)
         bus(1'b1, 6'h08, r[72:41]);
         bus(1'b1, 6'h0C, r[40:9]);
         bus(1'b1, 6'h00, 32'h1);
         q = 32'h0;
         for (n = 0; n < 40 && q[0] !== 1'b1; n = n + 1)
            bus(1'b0, 6'h14, 32'h0);
         `CHK(q[1:0], {r[0], 1'b1})
         if (q[0] !== 1'b1)
            complete_run;
         `CHK(irq, |(maskVal & {r[0], 1'b1}))
         bus(1'b0, 6'h10, 32'h0);
         `CHK(q, {24'h0, r[7:0]})
         bus(1'b1, 6'h14, 32'h3);
      end
   endtask
   initial begin
      rows[0] = {8'h5A, 32'h10000, 32'h100, 1'b1, 8'h00};
      rows[1] = {8'h5A, 32'h10000, 32'h100, 1'b0, 8'h21};
      rows[2] = {8'h5B, 32'h10000, 32'h300, 1'b1, 8'h11};
      rows[3] = {8'h5A, 32'h10000, 32'h300, 1'b0, 8'h00};
      rows[4] = {8'h5A, 32'h7FFF, 32'h380, 1'b1, 8'h05};
      rows[5] = {8'h5A, 32'h8000, 32'h380, 1'b0, 8'h00};
      rows[6] = {8'h5A, 32'h10000, 32'h8000, 1'b0, 8'h03};
      rows[7] = {8'h5A, 32'h10000, 32'h1C0, 1'b0, 8'h03};
      repeat (2) @(posedge clk);
      `CHK(avsWaitRequest, 1'b1)
      reset_n <= 1'b1;
      bus(1'b1, 6'h10, 32'hFF);
      bus(1'b0, 6'h10, 32'h0);
      `CHK(q, 32'h0)
      bus(1'b0, 6'h3C, 32'h0);
      `CHK(q, 32'h0)
      bus(1'b1, 6'h18, 32'h3);
      for (i = 0; i < 8; i = i + 1)
         run(rows[i]);
      writeEnablePin <= 1'b0;
      run({8'h5A, 32'h10000, 32'h400, 1'b1, 8'h41});
      writeEnablePin <= 1'b1;
      errorProtectFlag <= 1'b1;
      run({8'h5A, 32'h10000, 32'h400, 1'b0, 8'h41});
      bus(1'b0, 6'h20, 32'h0);
      `CHK(q, 32'h6)
      errorProtectFlag <= 1'b0;
      maskVal = 2'h2;
      bus(1'b1, 6'h18, 32'h2);
      bus(1'b0, 6'h18, 32'h0);
      `CHK(q, 32'h2)
      run({8'h5A, 32'h10000, 32'h400, 1'b0, 8'h00});
      run({8'hA5, 32'h0, 32'h4C0, 1'b0, 8'h17});
      bus(1'b1, 6'h00, 32'h1);
      bus(1'b0, 6'h20, 32'h0);
      `CHK(q, 32'h3)
      reset_n <= 1'b0;
      @(posedge clk);
      reset_n <= 1'b1;
      bus(1'b0, 6'h04, 32'h0);
      `CHK(q, 32'h0)
      bus(1'b0, 6'h10, 32'h0);
      `CHK(q, 32'h0)
      `CHK(irq, 1'b0)
      complete_run;
   end
endmodule // test_flash_program_result_checker
bind fprc_flash_program_result_checker fprc_chk chk (
   .clk            (clk),
   .reset_n        (reset_n),
   .avsAddress     (avsAddress),
   .avsRead        (avsRead),
   .avsWrite       (avsWrite),
   .avsWriteData   (avsWriteData),
   .avsByteEnable  (avsByteEnable),
   .avsReadData    (avsReadData),
   .avsWaitRequest (avsWaitRequest)
);
